/* File: logic/peripheral_irq_enable_gate.v */
/*
  Peripheral interrupt enable gate with its software registers, a
  combinational request to the core, and a sticky event status block.
  Assumes peripheral flags come from logic on clk; the core samples
  core_irq_req on clk.
*/
// Chosen here: the placing of the registers and the plain strobed port.
// Overview of operation
// R1 - Capture/compare unit one request passes only while enable bit 2 is one.
// R2 - Timer two period match request passes only while enable bit 1 is one.
// R3 - Timer one overflow request passes only while enable bit 0 is one.
// R4 - No peripheral request passes while the common peripheral enable is clear.
// R5 - Enable bits mask the request path only; flags are never changed.
`timescale 1ns/100ps
`include "irq_gate_defs.vh"
module peripheral_irq_enable_gate (
  input  wire                 clk,
  input  wire                 srst,
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [`DATA_W-1:0]   wdata,
  input  wire                 wr_stb,
  input  wire                 rd_stb,
  output reg  [`DATA_W-1:0]   rdata,
  input  wire                 capcomp_one_flag,
  input  wire                 timer_two_match_flag,
  input  wire                 timer_one_overflow_flag,
  output wire                 core_irq_req,
  output wire [`NUM_SRC-1:0]  src_req,
  output wire                 irq
);

  reg  [`NUM_SRC-1:0] periph_en_reg;
  reg                 master_en_reg;
  reg  [`NUM_SRC-1:0] status_reg;
  reg  [`NUM_SRC-1:0] status_next;
  reg  [`NUM_SRC-1:0] irq_enable_reg;
  reg  [`NUM_SRC-1:0] flag_d_reg;
  reg  [`DATA_W-1:0]  rdata_next;
  wire [`NUM_SRC-1:0] flags;
  wire [`NUM_SRC-1:0] rise;
  wire                capcomp_one_irq_en;
  wire                timer_two_match_irq_en;
  wire                timer_one_overflow_irq_en;
  wire                peripheral_irq_master_en;

  assign flags = {capcomp_one_flag, timer_two_match_flag, timer_one_overflow_flag};
  assign capcomp_one_irq_en        = periph_en_reg[`BIT_CAPCOMP_ONE];
  assign timer_two_match_irq_en    = periph_en_reg[`BIT_TIMER_TWO_MATCH];
  assign timer_one_overflow_irq_en = periph_en_reg[`BIT_TIMER_ONE_OVF];
  assign peripheral_irq_master_en  = master_en_reg;

  src_gate u_gate_capcomp (
    .flag      (capcomp_one_flag),
    .src_en    (capcomp_one_irq_en),
    .master_en (peripheral_irq_master_en),
    .req       (src_req[`BIT_CAPCOMP_ONE])
  ); // R1 R4 R5

  src_gate u_gate_tmr2 (
    .flag      (timer_two_match_flag),
    .src_en    (timer_two_match_irq_en),
    .master_en (peripheral_irq_master_en),
    .req       (src_req[`BIT_TIMER_TWO_MATCH])
  ); // R2 R4 R5

  src_gate u_gate_tmr1 (
    .flag      (timer_one_overflow_flag),
    .src_en    (timer_one_overflow_irq_en),
    .master_en (peripheral_irq_master_en),
    .req       (src_req[`BIT_TIMER_ONE_OVF])
  ); // R3 R4 R5

  // Level request to the core; combinational so masking acts at once
  assign core_irq_req = |src_req; // R4

  // Software registers; flags are inputs and have no write path
  always @(posedge clk) begin
    if (srst) begin
      periph_en_reg  <= `RST_PERIPH_EN;
      master_en_reg  <= `RST_MASTER_EN;
      irq_enable_reg <= `RST_IRQ_ENABLE;
    end else if (wr_stb) begin
      case (addr)
        `OFF_PERIPH_EN:  periph_en_reg  <= wdata[`NUM_SRC-1:0]; // R5
        `OFF_INTR_CTRL:  master_en_reg  <= wdata[`BIT_PERIPH_MASTER];
        `OFF_IRQ_ENABLE: irq_enable_reg <= wdata[`NUM_SRC-1:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky status: rising edge of a forwarded request; set wins over clear
  assign rise = src_req & ~flag_d_reg;

  always @* begin
    status_next = status_reg;
    if (wr_stb && (addr == `OFF_IRQ_CLEAR)) begin
      status_next = status_next & ~wdata[`NUM_SRC-1:0];
    end
    status_next = status_next | rise;
  end

  always @(posedge clk) begin
    if (srst) begin
      status_reg <= `RST_STATUS;
      flag_d_reg <= `RST_STATUS;
    end else begin
      status_reg <= status_next;
      flag_d_reg <= src_req;
    end
  end

  assign irq = |(status_reg & irq_enable_reg);

  always @* begin
    rdata_next = `READ_UNMAPPED;
    case (addr)
      `OFF_PERIPH_EN:  rdata_next[`NUM_SRC-1:0] = periph_en_reg;
      `OFF_INTR_CTRL:  rdata_next[`BIT_PERIPH_MASTER] = master_en_reg;
      `OFF_FLAGS:      rdata_next[`NUM_SRC-1:0] = flags;
      `OFF_IRQ_STATUS: rdata_next[`NUM_SRC-1:0] = status_reg;
      `OFF_IRQ_ENABLE: rdata_next[`NUM_SRC-1:0] = irq_enable_reg;
      default:         rdata_next = `READ_UNMAPPED;
    endcase
  end

  // Read data held only in the cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (srst) begin
      rdata <= `READ_UNMAPPED;
    end else if (rd_stb) begin
      rdata <= rdata_next;
    end else begin
      rdata <= `READ_UNMAPPED;
    end
  end

endmodule // peripheral_irq_enable_gate

/* File: logic/irq_gate_defs.vh */
/*
  Constants for the peripheral interrupt enable gate: register offsets,
  bit positions and reset values. Assumes inclusion by bare name.
*/
`ifndef IRQ_GATE_DEFS_VH
`define IRQ_GATE_DEFS_VH

`define ADDR_W                 4
`define DATA_W                 8
`define OFF_PERIPH_EN          4'h0
`define OFF_INTR_CTRL          4'h1
`define OFF_FLAGS              4'h2
`define OFF_IRQ_STATUS         4'h3
`define OFF_IRQ_CLEAR          4'h4
`define OFF_IRQ_ENABLE         4'h5
`define BIT_TIMER_ONE_OVF      0
`define BIT_TIMER_TWO_MATCH    1
`define BIT_CAPCOMP_ONE        2
`define BIT_PERIPH_MASTER      6
`define NUM_SRC                3
`define RST_PERIPH_EN          3'h0
`define RST_MASTER_EN          1'h0
`define RST_STATUS             3'h0
`define RST_IRQ_ENABLE         3'h0
`define READ_UNMAPPED          8'h00

`endif

/* File: logic/src_gate.v */
/*
  One source path: forwards a peripheral flag when its own enable and the
  common peripheral enable are both set. Assumes same-clock inputs.
*/
`timescale 1ns/100ps
module src_gate (
  input  wire flag,
  input  wire src_en,
  input  wire master_en,
  output wire req
);

  // Pure masking: the flag itself is never touched here
  assign req = flag & src_en & master_en;

endmodule // src_gate

/* File: test/peripheral_irq_enable_gate_checker.sv */
/* Checker for the gate: request and flag view relations.
   Assumes a bind onto the top module; sees its ports only. */
`timescale 1ns/100ps
`include "irq_gate_defs.vh"
module peripheral_irq_enable_gate_checker (
  input wire               clk,
  input wire               srst,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wdata,
  input wire               wr_stb,
  input wire               rd_stb,
  input wire [`DATA_W-1:0] rdata,
  input wire               capcomp_one_flag,
  input wire               timer_two_match_flag,
  input wire               timer_one_overflow_flag,
  input wire               core_irq_req,
  input wire [`NUM_SRC-1:0] src_req,
  input wire               irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  capcomp_gate_a: assert property (src_req[2] |-> capcomp_one_flag)
    else $error("capcomp request without flag");
  match_gate_a: assert property (src_req[1] |-> timer_two_match_flag)
    else $error("match request without flag");
  overflow_gate_a: assert property (src_req[0] |-> timer_one_overflow_flag)
    else $error("overflow request without flag");
  master_off_a: assert property (wr_stb && addr == `OFF_INTR_CTRL && !wdata[6]
    |=> src_req == 3'h0 && !core_irq_req) else $error("request with master off");
  core_or_a: assert property (core_irq_req == |src_req)
    else $error("core request differs from source requests");
  flag_view_a: assert property (rd_stb && addr == `OFF_FLAGS |=> rdata ==
    {5'h00, $past(capcomp_one_flag), $past(timer_two_match_flag),
    $past(timer_one_overflow_flag)}) else $error("flag view changed");
endmodule // peripheral_irq_enable_gate_checker

/* File: test/core_model.sv */
/* Core side model: samples the request as the core would.
   Assumes the gate's clock. */
`timescale 1ns/100ps
module core_model (
  input  wire clk,
  input  wire srst,
  input  wire core_irq_req,
  output reg  taken
);
  always @(posedge clk) taken <= srst ? 1'h0 : core_irq_req;
endmodule // core_model

/* File: test/peripheral_irq_enable_gate_tb.sv */
/* Bench: enable sweeps, master gating, status and irq over the bus.
   Assumes the design and core model are compiled first. */
`timescale 1ns/100ps
module peripheral_irq_enable_gate_tb;
  reg        clk = 0, srst = 1, wr_stb = 0, rd_stb = 0;
  reg  [3:0] addr = 4'h0;
  reg  [7:0] wdata = 8'h00;
  reg  [2:0] fl = 3'h0;
  wire [7:0] rdata;
  wire [2:0] src_req;
  wire       core_irq_req, irq, taken;
  integer    miscompares = 0, checks = 0, i;
  always #2 clk = ~clk;
  peripheral_irq_enable_gate u_peripheral_irq_enable_gate (.clk(clk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .capcomp_one_flag(fl[2]), .timer_two_match_flag(fl[1]),
    .timer_one_overflow_flag(fl[0]), .core_irq_req(core_irq_req), .src_req(src_req), .irq(irq));
  core_model u_core_model (.clk(clk), .srst(srst), .core_irq_req(core_irq_req), .taken(taken));
  task chk(input [39:0] nm, input [7:0] seen, input [7:0] exp); begin
    checks = checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value %0s exp %h seen %h", nm, exp, seen);
    end
  end endtask
  task wr(input [3:0] a, input [7:0] d); begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
    #1;
  end endtask
  task rd(input [3:0] a, input [7:0] e); begin
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    #1 chk("rdata", rdata, e);
  end endtask
  task end_of_test; begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    #1 chk("rst", {rdata[3:0], src_req, irq}, 8'h00);
    wr(4'h1, 8'h40);
    for (i = 0; i < 3; i = i + 1) begin
      fl <= 3'h1 << i;
      wr(4'h0, 8'h07 & ~(8'h01 << i));
      chk("src", src_req, 8'h00);
      wr(4'h0, 8'h01 << i);
      chk("src", src_req, 8'h01 << i);
    end
    fl <= 3'h7;
    wr(4'h0, 8'h07);
    wr(4'h1, 8'h00);
    chk("core", core_irq_req, 8'h00);
    rd(4'h2, 8'h07);
    wr(4'h4, 8'h07);
    wr(4'h5, 8'h02);
    fl <= 3'h1;
    wr(4'h1, 8'h40);
    rd(4'h3, 8'h01);
    chk("irq", irq, 8'h00);
    fl <= 3'h3;
    repeat (2) @(posedge clk);
    #1 chk("irq", irq, 8'h01);
    chk("taken", taken, 8'h01);
    wr(4'h4, 8'h03);
    rd(4'h3, 8'h00);
    chk("irq", irq, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'hF, 8'h00);
    end_of_test;
  end
endmodule // peripheral_irq_enable_gate_tb
bind peripheral_irq_enable_gate peripheral_irq_enable_gate_checker u_checker (.clk(clk),
  .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .capcomp_one_flag(capcomp_one_flag), .timer_two_match_flag(timer_two_match_flag),
  .timer_one_overflow_flag(timer_one_overflow_flag), .core_irq_req(core_irq_req),
  .src_req(src_req), .irq(irq));
